/* File: pkg/acpm_pkg.sv */
// Constants and types shared by the converter serial and power-mode control.
// Assumes one 100 MHz reference clock; the serial clock and frame select arrive as pins.
package acpm_pkg;

    // ------------------------------------------------------------------
    // Frame counting
    // ------------------------------------------------------------------
    localparam int unsigned CNT_W        = 5;
    localparam logic [4:0]  CNT_RESET    = 5'h00;
    localparam logic [4:0]  WIN_LO_EDGE  = 5'h02;   // First edge of the shutdown window
    localparam logic [4:0]  WIN_HI_EDGE  = 5'h0A;   // Edge that closes the window
    localparam logic [4:0]  FULL_FRAME   = 5'h10;   // Falling edges in a full frame
    localparam int unsigned LEAD_ZEROS   = 3;
    localparam int unsigned RES_BITS     = 12;
    localparam int unsigned WORD_BITS    = 16;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [11:0] HOLD_RESET   = 12'h000;
    localparam logic        PIN_IDLE_HI  = 1'b1;
    localparam logic        PIN_IDLE_LO  = 1'b0;

    // ------------------------------------------------------------------
    // Control states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_SHUT  = 4'h1,    // Analog off, waiting for a frame
        ST_IDLE  = 4'h2,    // Normal mode, select high
        ST_FRAME = 4'h4,    // Frame running
        ST_DONE  = 4'h8     // Full frame done, select still low
    } acpm_state_e;

endpackage : acpm_pkg

/* File: rtl/acpm_sync.sv */
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the input is asynchronous to i_ref_clk.
`timescale 1ns/1ps
module acpm_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic i_ref_clk,   // Reference clock
    input  wire logic i_resetn,    // Async reset, active low
    input  wire logic i_pin,       // Raw pin level
    output logic      o_level      // Filtered level
);

    // ------------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------------
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // Shift the pin through three flops
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s1_r <= RESET_VAL;
            s2_r <= RESET_VAL;
            s3_r <= RESET_VAL;
        end else begin
            s1_r <= i_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Accept a change once stages two and three agree
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_level <= RESET_VAL;
        end else if (s2_r == s3_r) begin
            o_level <= s3_r;
        end
    end

endmodule : acpm_sync

/* File: rtl/acpm_ctrl.sv */
// Serial interface and power-mode control of a single-channel converter.
// Assumes the host drives the frame select and serial clock; the analog core
// supplies a 12-bit result on i_sample_data, stable when the select falls.
`timescale 1ns/1ps
module acpm_ctrl (
    input  wire logic        i_ref_clk,              // 100 MHz reference clock
    input  wire logic        i_resetn,               // Async reset, active low
    input  wire logic        i_frame_sel_n,          // Frame select pin, active low
    input  wire logic        i_shift_clk,            // Serial clock pin
    input  wire logic        i_boot_shutdown,        // Power-on mode strap, 1 = shutdown
    input  wire logic [11:0] i_sample_data,          // Result from the analog core
    output logic             o_serial_result_out,    // Serial result data
    output logic             o_serial_result_oe_n,   // Result pin enable, low = driven
    output logic             o_analog_on,            // Analog circuitry enable
    output logic             o_sample_hold,          // One-cycle pulse: input held
    output logic             o_shutdown,             // Shutdown mode level
    output logic             o_powered_up,           // Fully powered level
    output logic             o_result_valid          // One-cycle pulse: valid word sent
);

    // ------------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------------
    logic sel_n_lvl;
    logic sclk_lvl;
    logic sel_n_prev_r;
    logic sclk_prev_r;
    logic sel_fall;
    logic sel_rise;
    logic sclk_fall;

    acpm_sync #(.RESET_VAL(acpm_pkg::PIN_IDLE_HI)) u_sync_sel (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_pin     (i_frame_sel_n),
        .o_level   (sel_n_lvl)
    );

    acpm_sync #(.RESET_VAL(acpm_pkg::PIN_IDLE_LO)) u_sync_sclk (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_pin     (i_shift_clk),
        .o_level   (sclk_lvl)
    );

    // Previous filtered levels
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sel_n_prev_r <= acpm_pkg::PIN_IDLE_HI;
            sclk_prev_r  <= acpm_pkg::PIN_IDLE_LO;
        end else begin
            sel_n_prev_r <= sel_n_lvl;
            sclk_prev_r  <= sclk_lvl;
        end
    end

    // Edge strobes on the filtered levels
    assign sel_fall  = sel_n_prev_r & ~sel_n_lvl;
    assign sel_rise  = ~sel_n_prev_r & sel_n_lvl;
    assign sclk_fall = sclk_prev_r & ~sclk_lvl;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Bit of the output word at a falling-edge count; zero past the end
    function automatic logic acpm_word_bit(input logic [15:0] word, input logic [4:0] idx);
        logic res;
        res = 1'b0;
        if (idx < acpm_pkg::FULL_FRAME) begin
            res = word[4'hF - idx[3:0]];
        end
        return res;
    endfunction : acpm_word_bit

    // ------------------------------------------------------------------
    // State and frame registers
    // ------------------------------------------------------------------
    acpm_pkg::acpm_state_e state_r;
    logic                  boot_done_r;
    logic                  wake_r;
    logic                  dummy_r;
    logic                  power_ok_r;
    logic [4:0]            fall_cnt_r;
    logic [11:0]           hold_r;
    logic [15:0]           word;
    logic                  frame_end;
    logic                  cut_to_shut;

    // Word: three leading zeros, twelve result bits, one trailing zero
    assign word = {3'h0, hold_r, 1'b0};

    // Sixteenth falling edge of a running frame
    assign frame_end = (state_r == acpm_pkg::ST_FRAME) && sclk_fall &&
                       (fall_cnt_r == (acpm_pkg::FULL_FRAME - 5'h01));

    // Select rising in a running frame that must end in shutdown
    // shutdown window
    always_comb begin
        cut_to_shut = 1'b0;
        if (fall_cnt_r < acpm_pkg::WIN_LO_EDGE) begin
            cut_to_shut = wake_r;
        end else if (fall_cnt_r < acpm_pkg::WIN_HI_EDGE) begin
            cut_to_shut = 1'b1;
        end
    end

    // Mode and frame sequencing
    // rise before refall
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r <= acpm_pkg::ST_IDLE;
        end else if (!boot_done_r) begin
            state_r <= i_boot_shutdown ? acpm_pkg::ST_SHUT : acpm_pkg::ST_IDLE;
        end else begin
            unique case (state_r)
                acpm_pkg::ST_SHUT: begin
                    if (sel_fall) begin
                        state_r <= acpm_pkg::ST_FRAME;
                    end
                end
                acpm_pkg::ST_IDLE: begin
                    if (sel_fall) begin
                        state_r <= acpm_pkg::ST_FRAME;
                    end
                end
                acpm_pkg::ST_FRAME: begin
                    if (sel_rise) begin
                        state_r <= cut_to_shut ? acpm_pkg::ST_SHUT : acpm_pkg::ST_IDLE;
                    end else if (frame_end) begin
                        state_r <= acpm_pkg::ST_DONE;
                    end
                end
                acpm_pkg::ST_DONE: begin
                    if (sel_rise) begin
                        state_r <= acpm_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Strap capture happens once after reset release
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            boot_done_r <= 1'b0;
        end else begin
            boot_done_r <= 1'b1;
        end
    end

    // Falling-edge count for the frame
    // count and clear
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fall_cnt_r <= acpm_pkg::CNT_RESET;
        end else if (sel_rise || sel_fall) begin
            fall_cnt_r <= acpm_pkg::CNT_RESET;
        end else if (sclk_fall && (state_r == acpm_pkg::ST_FRAME)) begin
            fall_cnt_r <= fall_cnt_r + 5'h01;
        end
    end

    // Wake-frame flag: set when a frame starts from shutdown
    // wake on select
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wake_r <= 1'b0;
        end else if (sel_fall && (state_r == acpm_pkg::ST_SHUT)) begin
            wake_r <= 1'b1;
        end else if (sel_rise || frame_end) begin
            wake_r <= 1'b0;
        end
    end

    // Full power after sixteen clocks of the wake frame
    // sixteen clocks powered
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            power_ok_r <= 1'b0;
        end else if (!boot_done_r) begin
            power_ok_r <= ~i_boot_shutdown;
        end else if (state_r == acpm_pkg::ST_SHUT) begin
            power_ok_r <= 1'b0;
        end else if (wake_r && sclk_fall && (fall_cnt_r == (acpm_pkg::FULL_FRAME - 5'h01))) begin
            power_ok_r <= 1'b1;
        end
    end

    // Dummy flag: the first conversion after power-up is unusable
    // one dummy conversion
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dummy_r <= 1'b1;
        end else if (state_r == acpm_pkg::ST_SHUT) begin
            dummy_r <= 1'b1;
        end else if (frame_end || (sel_rise && (state_r == acpm_pkg::ST_FRAME) &&
                                   (fall_cnt_r >= acpm_pkg::WIN_HI_EDGE))) begin
            dummy_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Sampling and serial output
    // ------------------------------------------------------------------
    // Hold the input at the start of a frame
    // sample on select
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            hold_r        <= acpm_pkg::HOLD_RESET;
            o_sample_hold <= 1'b0;
        end else begin
            o_sample_hold <= 1'b0;
            if (sel_fall && (state_r != acpm_pkg::ST_FRAME)) begin
                hold_r        <= i_sample_data;
                o_sample_hold <= 1'b1;
            end
        end
    end

    // Result data bit
    // zeros then MSB first
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_serial_result_out <= 1'b0;
        end else if (sel_fall) begin
            o_serial_result_out <= 1'b0;
        end else if (sclk_fall && (state_r == acpm_pkg::ST_FRAME)) begin
            o_serial_result_out <= acpm_word_bit(word, fall_cnt_r + 5'h01);
        end
    end

    // Result pin enable
    // abort floats pin
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_serial_result_oe_n <= 1'b1;
        end else if (sel_rise || frame_end) begin
            o_serial_result_oe_n <= 1'b1;
        end else if (sel_fall && (state_r != acpm_pkg::ST_FRAME) &&
                     (state_r != acpm_pkg::ST_DONE)) begin
            o_serial_result_oe_n <= 1'b0;
        end
    end

    // Valid-word pulse at the end of a non-dummy full frame
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_result_valid <= 1'b0;
        end else begin
            o_result_valid <= frame_end && !dummy_r;
        end
    end

    // ------------------------------------------------------------------
    // Power outputs
    // ------------------------------------------------------------------
    // Analog enable and mode flags
    // analog off in shutdown
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_analog_on <= 1'b0;
            o_shutdown  <= 1'b0;
        end else begin
            o_analog_on <= (state_r != acpm_pkg::ST_SHUT) && boot_done_r;
            o_shutdown  <= (state_r == acpm_pkg::ST_SHUT);
        end
    end

    assign o_powered_up = power_ok_r;

endmodule : acpm_ctrl

/* File: dv/acpm_ctrl_monitor.sv */
// Port checker for the converter control block.
// Assumes it is bound to acpm_ctrl; one clock domain.
`timescale 1ns/1ps
module acpm_ctrl_monitor (
    input wire logic i_ref_clk,            // Clock
    input wire logic i_resetn,             // Reset, active low
    input wire logic o_serial_result_out,  // Result bit
    input wire logic o_serial_result_oe_n, // Result enable, low = driven
    input wire logic o_analog_on,          // Analog enable
    input wire logic o_sample_hold,        // Hold pulse
    input wire logic o_shutdown,           // Shutdown level
    input wire logic o_powered_up,         // Powered level
    input wire logic o_result_valid        // Valid word pulse
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    property p_analog_off;
        o_shutdown && $past(o_shutdown) |-> !o_analog_on;
    endproperty
    a_analog_off: assert property (p_analog_off) else $error("analog on in shutdown");
    property p_hold_at_start;
        $fell(o_serial_result_oe_n) |-> o_sample_hold;
    endproperty
    a_hold_at_start: assert property (p_hold_at_start) else $error("no hold at frame start");
    property p_hold_pulse;
        o_sample_hold |=> !o_sample_hold;
    endproperty
    a_hold_pulse: assert property (p_hold_pulse) else $error("hold longer than one cycle");
    property p_lead_zero;
        $fell(o_serial_result_oe_n) |-> (o_serial_result_oe_n || !o_serial_result_out) [*8];
    endproperty
    a_lead_zero: assert property (p_lead_zero) else $error("leading bit not zero");
    property p_valid_end;
        o_result_valid |-> $rose(o_serial_result_oe_n);
    endproperty
    a_valid_end: assert property (p_valid_end) else $error("valid not at word end");
    property p_valid_on;
        o_result_valid |-> o_analog_on && !o_shutdown;
    endproperty
    a_valid_on: assert property (p_valid_on) else $error("valid while powered down");
    property p_pwr_shut;
        o_shutdown [*2] |-> !o_powered_up;
    endproperty
    a_pwr_shut: assert property (p_pwr_shut) else $error("powered in shutdown");
    property p_wake_on;
        o_sample_hold |-> ##[0:3] o_analog_on;
    endproperty
    a_wake_on: assert property (p_wake_on) else $error("analog not on after frame start");
    property p_shut_float;
        $rose(o_shutdown) |-> o_serial_result_oe_n;
    endproperty
    a_shut_float: assert property (p_shut_float) else $error("result pin driven in shutdown");
endmodule : acpm_ctrl_monitor

bind acpm_ctrl acpm_ctrl_monitor acpm_ctrl_monitor_inst (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .o_serial_result_out(o_serial_result_out),
    .o_serial_result_oe_n(o_serial_result_oe_n), .o_analog_on(o_analog_on),
    .o_sample_hold(o_sample_hold), .o_shutdown(o_shutdown), .o_powered_up(o_powered_up),
    .o_result_valid(o_result_valid));

/* File: dv/acpm_host_model.sv */
// Host serial port model: frame select, serial clock, result capture.
// Assumes calls start just after a reference clock edge.
`timescale 1ns/1ps
module acpm_host_model #(
    parameter int QUIET_NS = 200   // Quiet time between frames
) (
    output logic      o_frame_sel_n, // Frame select, active low
    output logic      o_shift_clk,   // Serial clock, still outside frames
    input  wire logic i_result,      // Result pin
    input  wire logic i_result_oe_n  // Result enable, low = driven
);
    // Idle pins: select high, clock parked high
    initial begin
        o_frame_sel_n = 1'b1;
        o_shift_clk = 1'b1;
    end

    // One frame of n falling clock edges; bits taken late in the high
    // phase because the device answers a few reference clocks after a fall
    task automatic run_frame(input int n, output logic [15:0] word);
        word = 16'h0000;
        o_frame_sel_n = 1'b0;
        #80;
        for (int k = 1; k <= n; k++) begin
            if (k <= 16) word[16-k] = (i_result_oe_n === 1'b0) ? i_result : 1'bx;
            o_shift_clk = 1'b0;
            #40;
            o_shift_clk = 1'b1;
            #40;
        end
        o_frame_sel_n = 1'b1;
        #(QUIET_NS);
    endtask : run_frame
endmodule : acpm_host_model

/* File: dv/acpm_ctrl_tb.sv */
// Self-checking bench for the converter serial and power-mode control.
// Assumes acpm_ctrl with the host model on its pins.
`timescale 1ns/1ps
module acpm_ctrl_tb;
    logic        i_ref_clk, i_resetn, i_boot_shutdown, fsel_n, sclk;
    logic [11:0] i_sample_data;
    logic        ser, oe_n, ana_on, hold, shut, pwr, valid;
    logic [15:0] word;
    int          fail_count, tests_run, valid_cnt, v0;

    acpm_ctrl acpm_ctrl_inst (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_frame_sel_n(fsel_n),
        .i_shift_clk(sclk), .i_boot_shutdown(i_boot_shutdown), .i_sample_data(i_sample_data),
        .o_serial_result_out(ser), .o_serial_result_oe_n(oe_n), .o_analog_on(ana_on),
        .o_sample_hold(hold), .o_shutdown(shut), .o_powered_up(pwr), .o_result_valid(valid));
    acpm_host_model acpm_host_model_inst (.o_frame_sel_n(fsel_n), .o_shift_clk(sclk),
        .i_result(ser), .i_result_oe_n(oe_n));

    // ------------------------------------------------------------
    // Clock, valid counter and helpers
    // ------------------------------------------------------------
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    // Count valid pulses
    always @(posedge i_ref_clk) begin
        if (valid === 1'b1) valid_cnt <= valid_cnt + 1;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    task automatic do_reset(input logic strap);
        i_resetn = 1'b0;
        i_boot_shutdown = strap;
        repeat (16) @(posedge i_ref_clk);
        #2 i_resetn = 1'b1;
        repeat (8) @(posedge i_ref_clk);
        #2;
    endtask : do_reset

    task automatic frame(input int n);
        acpm_host_model_inst.run_frame(n, word);
        repeat (10) @(posedge i_ref_clk);
        #2;
    endtask : frame

    // Full frame of n falls that must yield a valid word of d
    task automatic full(input int n, input logic [11:0] d);
        i_sample_data = d;
        v0 = valid_cnt;
        frame(n);
        check(word, {3'h0, d, 1'h0});
        check(16'(valid_cnt), 16'(v0 + 1));
    endtask : full

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic s_boot_normal();
        do_reset(1'b0);
        check(16'(shut), 16'h0000);
        v0 = valid_cnt;
        frame(16);
        check(16'(valid_cnt), 16'(v0));
        full(20, 12'hA5C);
        full(16, 12'h3C1);
    endtask : s_boot_normal

    task automatic s_glitch_abort();
        frame(1);
        check(16'(shut), 16'h0000);
        v0 = valid_cnt;
        frame(12);
        check(16'({shut, oe_n}), 16'h0001);
        check(16'(valid_cnt), 16'(v0));
        full(16, 12'h801);
    endtask : s_glitch_abort

    task automatic s_shut_wake();
        int cuts[2] = '{2, 9};
        foreach (cuts[i]) begin
            frame(cuts[i]);
            check(16'({shut, ana_on, oe_n}), 16'h0005);
            v0 = valid_cnt;
            frame(16);
            check(16'({shut, pwr}), 16'h0001);
            check(16'(valid_cnt), 16'(v0));
            full(16, 12'h7FE);
        end
    endtask : s_shut_wake

    task automatic s_wake_cut();
        frame(5);
        frame(9);
        check(16'(shut), 16'h0001);
        frame(1);
        check(16'(shut), 16'h0001);
        frame(10);
        check(16'(shut), 16'h0000);
        full(16, 12'hFFF);
    endtask : s_wake_cut

    task automatic s_strap_shut();
        do_reset(1'b1);
        check(16'({shut, ana_on, pwr}), 16'h0004);
        frame(16);
        check(16'({shut, pwr}), 16'h0001);
        full(16, 12'h001);
    endtask : s_strap_shut

    // Main sequence and watchdog
    initial begin
        fail_count = 0;
        tests_run = 0;
        valid_cnt = 0;
        i_resetn = 1'b0;
        i_boot_shutdown = 1'b0;
        i_sample_data = 12'h000;
        @(posedge i_ref_clk);
        #2;
        s_boot_normal();
        s_glitch_abort();
        s_shut_wake();
        s_wake_cut();
        s_strap_shut();
        finish_test();
    end

    initial begin
        #400000;
        fail_count++;
        finish_test();
    end
endmodule : acpm_ctrl_tb
